// File: include/usb_irq_cfg_defs.svh
// Offsets, field positions, reset values and timing counts of the interrupt configuration block
`ifndef USB_IRQ_CFG_DEFS_SVH
`define USB_IRQ_CFG_DEFS_SVH

// Register byte offsets
`define IRQ_CFG_OFS         12'h210
`define TEST_CTRL_OFS       12'h212
`define IRQ_EN_OFS          12'h214

// Reset values and bus reset masks
`define IRQ_CFG_RESET       8'hFC
`define IRQ_CFG_BUSRST_ONES 8'hFC
`define TEST_CTRL_RESET     16'h0008
`define IRQ_EN_RESET        32'h00000000
`define IRQ_EN_BUSRST_KEEP  32'h00000001

// Configuration fields
`define CFG_POL_BIT         3'h0
`define CFG_PULSE_BIT       3'h1
`define CFG_OUT_HI          3'h3
`define CFG_OUT_LO          3'h2
`define CFG_IN_HI           3'h5
`define CFG_IN_LO           3'h4
`define CFG_CTRL_HI         3'h7
`define CFG_CTRL_LO         3'h6

// Handshake mode codes
`define MODE_ALL            2'h0
`define MODE_ACK_ONLY       2'h1

// Enable and status bit positions
`define EN_BUS_RESET        5'h00
`define EN_SOF              5'h01
`define EN_SUSPEND          5'h02
`define EN_RESUME           5'h03
`define EN_HS_STATUS        5'h04
`define EN_SETUP            5'h08
`define EN_EP_BASE          5'h0A

// Pulse timing
`define CLK_PERIOD_NS       4
`define IRQ_PULSE_NS        60
`define IRQ_PULSE_CYCLES    ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: include/usb_irq_cfg_pkg.sv
// Types shared by the interrupt configuration block
package usb_irq_cfg_pkg;

	typedef enum logic [2:0] {
		HS_ACK  = 3'h1,
		HS_NAK  = 3'h2,
		HS_NYET = 3'h4
	} hs_kind_e;

	// One handshake seen or sent by the serial engine
	typedef struct packed {
		logic       valid;
		logic [2:0] ep;
		logic       dir_in;
		logic       setup;
		hs_kind_e   kind;
	} hs_event_s;

	// One-cycle bus event strobes
	typedef struct packed {
		logic bus_reset;
		logic sof;
		logic suspend;
		logic resume;
		logic hs_status;
	} bus_event_s;

	typedef enum logic [1:0] {
		PULSE_IDLE   = 2'h1,
		PULSE_ACTIVE = 2'h2
	} pulse_state_e;

endpackage

// File: rtl/irq_pulse_timer.sv
// Fixed-length pulse generator for the edge-signalled interrupt mode
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_cfg_defs.svh"

module irq_pulse_timer (
	input  wire logic CLK,
	input  wire logic RESET,
	input  wire logic start,
	output var  logic active
);

	localparam logic [3:0] pulse_last = 4'(`IRQ_PULSE_CYCLES - 1);

	usb_irq_cfg_pkg::pulse_state_e state;
	logic [3:0]                    count;

	// Starts while a pulse runs are merged into it, so pulses never stretch
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state  <= usb_irq_cfg_pkg::PULSE_IDLE;
			count  <= 4'h0;
			active <= 1'b0;
		end else begin
			unique case (state)
				usb_irq_cfg_pkg::PULSE_IDLE: begin
					if (start) begin
						state  <= usb_irq_cfg_pkg::PULSE_ACTIVE;
						count  <= 4'h0;
						active <= 1'b1;
					end
				end
				usb_irq_cfg_pkg::PULSE_ACTIVE: begin
					if (count == pulse_last) begin
						state  <= usb_irq_cfg_pkg::PULSE_IDLE;
						active <= 1'b0;
					end else begin
						count <= count + 4'h1;
					end
				end
				default: begin
					state  <= usb_irq_cfg_pkg::PULSE_IDLE;
					active <= 1'b0;
				end
			endcase
		end
	end

	sequence pulse_body;
		active [*8] ##1 active [*7];
	endsequence

	pulse_len_a: assert property (@(posedge CLK) disable iff (RESET)
		(start && !active) |=> pulse_body ##1 !active)
		else $error("interrupt pulse is not fifteen cycles long");

endmodule
`default_nettype wire

// File: rtl/usb_irq_config.sv
// Interrupt configuration, handshake filtering and interrupt pin generation
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_cfg_defs.svh"

// Contract
// - Eight-bit configuration register holds mode fields, polarity and signalling bits.
// - Received or sent ACK, NAK, NYET raise interrupts filtered by mode field.
// - Control field: 00 ACK and NAK, 01 ACK only, 1X ACK plus first NAK.
// - IN field: 00 ACK and NAK, 01 ACK only, 1X ACK plus first NAK.
// - OUT field: 00 ACK, NYET, NAK; 01 ACK, NYET; 1X adds first NAK.
// - First NAK follows an earlier ACK on that endpoint; repeated NAKs suppressed.
// - Endpoint 0 uses control field, data IN uses IN field, data OUT uses OUT.
// - Polarity bit clear gives active-low pin, set gives active-high pin.
// - Signalling bit clear holds a level, set gives one 60 ns pulse per interrupt.
// - Hardware reset clears pin controls; both resets set the mode fields to ones.
// - Test register sits at its own offset, or upper half of the wide word.
// - Each endpoint interrupt is gated by its own receive or transmit enable.
// - Global enable cleared suppresses the interrupt pin completely.
// - Frame, suspend, resume, bus reset, setup and speed status have own enables.
// - Bus reset clears every enable except the bus reset enable.
// - Setting global enable with an unmasked pending interrupt asserts the pin immediately.
module usb_irq_config (
	input  wire logic                          CLK,
	input  wire logic                          RESET,
	input  wire logic                          GLOBAL_IRQ_EN,
	input  wire usb_irq_cfg_pkg::hs_event_s    HS_EVENT,
	input  wire usb_irq_cfg_pkg::bus_event_s   BUS_EVENT,
	input  wire logic [11:0]                   REG_ADDR,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	input  wire logic                          REG_WIDE,
	input  wire logic [3:0]                    REG_BE,
	input  wire logic [31:0]                   REG_WDATA,
	output var  logic [31:0]                   REG_RDATA,
	input  wire logic [31:0]                   IRQ_STATUS_CLEAR,
	output var  logic [31:0]                   IRQ_STATUS,
	output var  logic                          IRQ
);

	localparam logic [11:0] cfg_ofs = `IRQ_CFG_OFS;
	localparam logic [11:0] en_ofs  = `IRQ_EN_OFS;

	logic [7:0]  irq_output_config;
	logic [15:0] test_control;
	logic [31:0] irq_source_enable;
	logic [15:0] acked;
	logic [31:0] set_vec;
	logic [31:0] wdata;
	logic [3:0]  wbe;
	logic        cfg_sel;
	logic        en_sel;
	logic [31:0] rd_word;
	logic [4:0]  ep_bit;
	logic [3:0]  trk_idx;
	logic [1:0]  hs_mode;
	logic        first_nak;
	logic        hs_qual;
	logic        unmasked;
	logic        global_q;
	logic        pulse_start;
	logic        pulse_active;
	logic        irq_assert;

	wire logic       irq_polarity       = irq_output_config[`CFG_POL_BIT];
	wire logic       irq_pulse_select   = irq_output_config[`CFG_PULSE_BIT];
	wire logic [1:0] ctrl_ep_handshake_mode = irq_output_config[`CFG_CTRL_HI:`CFG_CTRL_LO];
	wire logic [1:0] in_ep_handshake_mode   = irq_output_config[`CFG_IN_HI:`CFG_IN_LO];
	wire logic [1:0] out_ep_handshake_mode  = irq_output_config[`CFG_OUT_HI:`CFG_OUT_LO];

	// Mode filter shared by all three fields
	function automatic logic qualifies(
		input logic [1:0]                mode,
		input usb_irq_cfg_pkg::hs_kind_e kind,
		input logic                      first,
		input logic                      nyet_ok
	);
		logic q;
		q = 1'b0;
		unique case (kind)
			usb_irq_cfg_pkg::HS_ACK:  q = 1'b1;
			usb_irq_cfg_pkg::HS_NYET: q = nyet_ok;
			usb_irq_cfg_pkg::HS_NAK:  q = (mode == `MODE_ALL) || (mode[1] && first);
			default:                  q = 1'b0;
		endcase
		return q;
	endfunction

	// Narrow accesses are steered onto the half of the word they address
	always_comb begin
		if (REG_WIDE) begin
			wdata = REG_WDATA;
			wbe   = REG_BE;
		end else if (REG_ADDR[1]) begin
			wdata = {REG_WDATA[15:0], 16'h0000};
			wbe   = {REG_BE[1:0], 2'h0};
		end else begin
			wdata = {16'h0000, REG_WDATA[15:0]};
			wbe   = {2'h0, REG_BE[1:0]};
		end
		cfg_sel = REG_ADDR[11:2] == cfg_ofs[11:2];
		en_sel  = REG_ADDR[11:2] == en_ofs[11:2];
	end

	// Configuration byte; bus reset keeps only the pin controls
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_output_config <= `IRQ_CFG_RESET;
		end else if (BUS_EVENT.bus_reset) begin
			irq_output_config <= irq_output_config | `IRQ_CFG_BUSRST_ONES;
		end else if (REG_WR && cfg_sel && wbe[0]) begin
			irq_output_config <= wdata[7:0];
		end
	end

	// Test register shares the upper half of the configuration word
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			test_control <= `TEST_CTRL_RESET;
		end else if (BUS_EVENT.bus_reset) begin
			test_control <= `TEST_CTRL_RESET;
		end else if (REG_WR && cfg_sel) begin
			if (wbe[2]) begin
				test_control[7:0] <= wdata[23:16];
			end
			if (wbe[3]) begin
				test_control[15:8] <= wdata[31:24];
			end
		end
	end

	// Enable register, one byte lane per generate step
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_en_lane
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					irq_source_enable[lane*8 +: 8] <= 8'(`IRQ_EN_RESET >> (lane*8));
				end else if (BUS_EVENT.bus_reset) begin
					irq_source_enable[lane*8 +: 8] <= irq_source_enable[lane*8 +: 8] &
						8'(`IRQ_EN_BUSRST_KEEP >> (lane*8));
				end else if (REG_WR && en_sel && wbe[lane]) begin
					irq_source_enable[lane*8 +: 8] <= wdata[lane*8 +: 8];
				end
			end
		end
	endgenerate

	// Read path; a narrow read returns the addressed half in the low bits
	always_comb begin
		if (cfg_sel) begin
			rd_word = {test_control, 8'h00, irq_output_config};
		end else if (en_sel) begin
			rd_word = irq_source_enable;
		end else begin
			rd_word = 32'h00000000;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			if (REG_WIDE) begin
				REG_RDATA <= rd_word;
			end else begin
				REG_RDATA <= {16'h0000, REG_ADDR[1] ? rd_word[31:16] : rd_word[15:0]};
			end
		end
	end

	// Handshake routing to a mode field and to a status bit
	always_comb begin
		trk_idx   = {HS_EVENT.dir_in, HS_EVENT.ep};
		first_nak = acked[trk_idx];
		if (HS_EVENT.ep == 3'h0) begin
			hs_mode = ctrl_ep_handshake_mode;
		end else if (HS_EVENT.dir_in) begin
			hs_mode = in_ep_handshake_mode;
		end else begin
			hs_mode = out_ep_handshake_mode;
		end
		hs_qual = HS_EVENT.valid && qualifies(hs_mode, HS_EVENT.kind, first_nak,
			(HS_EVENT.ep != 3'h0) && !HS_EVENT.dir_in);
		if (HS_EVENT.setup) begin
			ep_bit = `EN_SETUP;
		end else begin
			ep_bit = 5'(`EN_EP_BASE + {HS_EVENT.ep, 1'b0} + {4'h0, HS_EVENT.dir_in});
		end
		set_vec = 32'h00000000;
		set_vec[ep_bit]        = hs_qual;
		set_vec[`EN_BUS_RESET] = BUS_EVENT.bus_reset;
		set_vec[`EN_SOF]       = BUS_EVENT.sof;
		set_vec[`EN_SUSPEND]   = BUS_EVENT.suspend;
		set_vec[`EN_RESUME]    = BUS_EVENT.resume;
		set_vec[`EN_HS_STATUS] = BUS_EVENT.hs_status;
	end

	// ACK arms the first-NAK flag, any NAK disarms it so later NAKs stay quiet
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			acked <= 16'h0000;
		end else if (BUS_EVENT.bus_reset) begin
			acked <= 16'h0000;
		end else if (HS_EVENT.valid) begin
			if (HS_EVENT.kind == usb_irq_cfg_pkg::HS_ACK) begin
				acked[trk_idx] <= 1'b1;
			end else if (HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK) begin
				acked[trk_idx] <= 1'b0;
			end
		end
	end

	// Sticky status; a new event outranks a clear in the same cycle
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			IRQ_STATUS <= 32'h00000000;
		end else begin
			IRQ_STATUS <= (IRQ_STATUS & ~IRQ_STATUS_CLEAR) | set_vec;
		end
	end

	// Pulse starts on each new unmasked event, or when global enable rises over a pending one
	always_comb begin
		unmasked    = |(IRQ_STATUS & irq_source_enable);
		pulse_start = GLOBAL_IRQ_EN && irq_pulse_select &&
			((|(set_vec & irq_source_enable)) || (unmasked && !global_q));
		if (!GLOBAL_IRQ_EN) begin
			irq_assert = 1'b0;
		end else if (irq_pulse_select) begin
			irq_assert = pulse_active;
		end else begin
			irq_assert = unmasked;
		end
	end

	irq_pulse_timer u_pulse (
		.CLK    (CLK),
		.RESET  (RESET),
		.start  (pulse_start),
		.active (pulse_active)
	);

	// Pin register; idles high because the reset polarity is active low
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			IRQ      <= 1'b1;
			global_q <= 1'b0;
		end else begin
			IRQ      <= irq_polarity ? irq_assert : !irq_assert;
			global_q <= GLOBAL_IRQ_EN;
		end
	end

	cfg_busrst_a: assert property (@(posedge CLK) disable iff (RESET)
		BUS_EVENT.bus_reset |=> irq_output_config[7:2] == 6'h3F &&
			irq_output_config[1:0] == $past(irq_output_config[1:0]))
		else $error("bus reset did not restore the mode fields");

	en_busrst_a: assert property (@(posedge CLK) disable iff (RESET)
		BUS_EVENT.bus_reset |=> irq_source_enable[31:1] == 31'h00000000 &&
			irq_source_enable[0] == $past(irq_source_enable[0]))
		else $error("bus reset left an enable set or changed the reset enable");

	level_out_a: assert property (@(posedge CLK) disable iff (RESET)
		(GLOBAL_IRQ_EN && unmasked && !irq_pulse_select && irq_polarity) |=> IRQ)
		else $error("level interrupt not driven active high");

	global_off_a: assert property (@(posedge CLK) disable iff (RESET)
		!GLOBAL_IRQ_EN |=> IRQ == !$past(irq_polarity))
		else $error("interrupt pin active while globally disabled");

	sequence ctrl_repeat_nak;
		HS_EVENT.valid && HS_EVENT.ep == 3'h0 && !HS_EVENT.setup &&
			HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK && ctrl_ep_handshake_mode[1] && !acked[trk_idx];
	endsequence

	first_nak_a: assert property (@(posedge CLK) disable iff (RESET)
		ctrl_repeat_nak |-> !set_vec[ep_bit])
		else $error("repeated control NAK raised an interrupt");

	ack_only_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.ep != 3'h0 && HS_EVENT.dir_in && !HS_EVENT.setup &&
			HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK && in_ep_handshake_mode == `MODE_ACK_ONLY) |-> !set_vec[ep_bit])
		else $error("NAK raised an interrupt in acknowledge-only mode");

	out_nyet_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.ep != 3'h0 && !HS_EVENT.dir_in &&
			HS_EVENT.kind == usb_irq_cfg_pkg::HS_NYET) |=> IRQ_STATUS[$past(ep_bit)])
		else $error("NYET on a data OUT endpoint was not recorded");

	ack_set_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.kind == usb_irq_cfg_pkg::HS_ACK) |=> IRQ_STATUS[$past(ep_bit)])
		else $error("ACK did not set its status bit");

	set_wins_a: assert property (@(posedge CLK) disable iff (RESET)
		|(set_vec & IRQ_STATUS_CLEAR) |=>
			(IRQ_STATUS & $past(set_vec & IRQ_STATUS_CLEAR)) == $past(set_vec & IRQ_STATUS_CLEAR))
		else $error("clear beat a simultaneous event");

	wide_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(REG_RD && REG_WIDE && cfg_sel) |=>
			REG_RDATA == {$past(test_control), 8'h00, $past(irq_output_config)})
		else $error("wide read of the configuration word is wrong");

	// Mode field, bus event, enable gating and narrow register view checks
	ctrl_ack_only_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.ep == 3'h0 && HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK &&
			ctrl_ep_handshake_mode == `MODE_ACK_ONLY) |-> !set_vec[ep_bit])
		else $error("control NAK raised an interrupt in acknowledge-only mode");

	in_first_nak_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.ep != 3'h0 && HS_EVENT.dir_in && !HS_EVENT.setup &&
			HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK && in_ep_handshake_mode[1] && acked[trk_idx])
			|=> IRQ_STATUS[$past(ep_bit)])
		else $error("first NAK on a data IN endpoint was not recorded");

	out_all_nak_a: assert property (@(posedge CLK) disable iff (RESET)
		(HS_EVENT.valid && HS_EVENT.ep != 3'h0 && !HS_EVENT.dir_in &&
			HS_EVENT.kind == usb_irq_cfg_pkg::HS_NAK && out_ep_handshake_mode == `MODE_ALL)
			|=> IRQ_STATUS[$past(ep_bit)])
		else $error("NAK on a data OUT endpoint dropped in the all-events mode");

	suspend_set_a: assert property (@(posedge CLK) disable iff (RESET)
		BUS_EVENT.suspend |=> IRQ_STATUS[`EN_SUSPEND])
		else $error("suspend event was not recorded");

	masked_idle_a: assert property (@(posedge CLK) disable iff (RESET)
		(GLOBAL_IRQ_EN && !irq_pulse_select && !unmasked) |=> IRQ == !$past(irq_polarity))
		else $error("level interrupt driven with no unmasked source");

	global_rise_a: assert property (@(posedge CLK) disable iff (RESET)
		(GLOBAL_IRQ_EN && !global_q && unmasked && !irq_pulse_select) |=> IRQ == $past(irq_polarity))
		else $error("pending interrupt not shown when global enable rose");

	narrow_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(REG_RD && !REG_WIDE && cfg_sel && REG_ADDR[1]) |=> REG_RDATA == {16'h0000, $past(test_control)})
		else $error("narrow read of the test register is wrong");

endmodule
`default_nettype wire

// File: verification/irq_host_model.sv
// Host side model that decodes the interrupt pin and measures its active runs
`timescale 1ns/100ps
`default_nettype none

module irq_host_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       irq_pin,
	input  wire logic       polarity,
	output var  logic       active,
	output var  logic [7:0] run_len,
	output var  logic [7:0] pulses
);
	logic [7:0] count;

	// Pin read with the polarity the host programmed
	assign active = polarity ? irq_pin : ~irq_pin;

	// Length of the last active run and number of activations seen
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= 8'h00;
			run_len <= 8'h00;
			pulses <= 8'h00;
		end else if (active) begin
			count <= count + 8'h01;
			if (count == 8'h00) begin
				pulses <= pulses + 8'h01;
			end
		end else begin
			if (count != 8'h00) begin
				run_len <= count;
			end
			count <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the interrupt configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
	$display("FAIL %0t %s", $time, msg); end end

module testbench;
	localparam int PULSE_EXP = (60 + 3) / 4; // 60 ns at 4 ns, rounded up
	logic                        CLK = 1'b0;
	logic                        RESET = 1'b1;
	logic                        GLOBAL_IRQ_EN = 1'b0;
	usb_irq_cfg_pkg::hs_event_s  HS_EVENT = '0;
	usb_irq_cfg_pkg::bus_event_s BUS_EVENT = '0;
	logic [11:0]                 REG_ADDR = 12'h000;
	logic                        REG_WR = 1'b0;
	logic                        REG_RD = 1'b0;
	logic                        REG_WIDE = 1'b0;
	logic [3:0]                  REG_BE = 4'h0;
	logic [31:0]                 REG_WDATA = 32'h0;
	logic [31:0]                 IRQ_STATUS_CLEAR = 32'h0;
	logic [31:0]                 REG_RDATA;
	logic [31:0]                 IRQ_STATUS;
	logic                        IRQ;
	logic                        pol = 1'b0;
	logic                        host_active;
	logic [7:0]                  run_len;
	logic [7:0]                  pulses;
	int                          failures = 0;
	int                          samples_checked = 0;
	int                          cycles = 0;

	always #2 CLK = ~CLK;

	usb_irq_config i_dut (.CLK(CLK), .RESET(RESET), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .HS_EVENT(HS_EVENT),
		.BUS_EVENT(BUS_EVENT), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WIDE(REG_WIDE),
		.REG_BE(REG_BE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .IRQ_STATUS_CLEAR(IRQ_STATUS_CLEAR),
		.IRQ_STATUS(IRQ_STATUS), .IRQ(IRQ));

	irq_host_model i_host (.clk(CLK), .reset(RESET), .irq_pin(IRQ), .polarity(pol), .active(host_active),
		.run_len(run_len), .pulses(pulses));

	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			close_out();
		end
	end

	// Bus cycles start and end at a falling edge; an idle cycle after each keeps strobes from toggling twice at once
	task automatic reg_wr(input logic [11:0] a, input logic w, input logic [3:0] be, input logic [31:0] d);
		REG_ADDR = a;
		REG_WIDE = w;
		REG_BE = be;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge CLK);
		REG_WR = 1'b0;
		@(negedge CLK);
	endtask

	task automatic reg_rd(input logic [11:0] a, input logic w, output logic [31:0] d);
		REG_ADDR = a;
		REG_WIDE = w;
		REG_RD = 1'b1;
		@(negedge CLK);
		REG_RD = 1'b0;
		d = REG_RDATA;
		@(negedge CLK);
	endtask

	task automatic hs(input logic [2:0] ep, input logic din, input logic su, input usb_irq_cfg_pkg::hs_kind_e k);
		HS_EVENT = '{1'b1, ep, din, su, k};
		@(negedge CLK);
		HS_EVENT.valid = 1'b0;
	endtask

	// Two cycles so the pin settles too
	task automatic clr();
		IRQ_STATUS_CLEAR = 32'hFFFFFFFF;
		@(negedge CLK);
		IRQ_STATUS_CLEAR = 32'h0;
		@(negedge CLK);
	endtask

	// Whether a handshake passes its mode field
	function automatic logic hit(input int f, input logic [1:0] m, input usb_irq_cfg_pkg::hs_kind_e k, input logic armed);
		case (k)
			usb_irq_cfg_pkg::HS_ACK: return 1'b1;
			usb_irq_cfg_pkg::HS_NYET: return f == 2;
			default: return m == 2'h0 || (m[1] && armed);
		endcase
	endfunction

	function automatic int sbit(input logic [2:0] ep, input logic din, input logic su);
		return su ? 8 : 10 + 2 * ep + din;
	endfunction

	initial begin
		logic [31:0] rd;
		logic [31:0] en;
		logic [7:0] np;
		logic [2:0] ep;
		logic din;
		logic su;
		logic armed;
		usb_irq_cfg_pkg::hs_kind_e kind;
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		RESET = 1'b0;
		void'($urandom(78));
		// Reset values, both access widths, refused accesses
		`CHECK(IRQ, 1'b1, "pin idle after reset")
		reg_wr(12'h212, 1'b0, 4'h3, 32'h00000008);
		reg_wr(12'h210, 1'b1, 4'h0, $urandom());
		reg_rd(12'h210, 1'b1, rd);
		`CHECK(rd, 32'h000800FC, "wide config word")
		reg_rd(12'h212, 1'b0, rd);
		`CHECK(rd[15:0], 16'h0008, "narrow test register")
		reg_rd(12'h214, 1'b1, rd);
		`CHECK(rd, 32'h0, "enable reset value")
		reg_rd(12'h300, 1'b1, rd);
		`CHECK(rd, 32'h0, "unmapped read")
		// Every mode of every field against ACK, NAK, NAK, NYET, NAK
		for (int m = 0; m < 4; m++) begin
			reg_wr(12'h210, 1'b1, 4'h1, {24'h0, m[1:0], m[1:0], m[1:0], 2'h0});
			for (int f = 0; f < 3; f++) begin
				ep = (f == 0) ? 3'h0 : 3'($urandom_range(7, 1));
				din = (f == 1) ? 1'b1 : (f == 2) ? 1'b0 : 1'($urandom_range(1));
				su = (f == 0) && !din && 1'($urandom_range(1));
				armed = 1'b0;
				for (int s = 0; s < 5; s++) begin
					kind = (s == 0) ? usb_irq_cfg_pkg::HS_ACK : (s == 3) ? usb_irq_cfg_pkg::HS_NYET : usb_irq_cfg_pkg::HS_NAK;
					hs(ep, din, su, kind);
					`CHECK(IRQ_STATUS[sbit(ep, din, su)], hit(f, m, kind, armed), "filter")
					armed = (kind == usb_irq_cfg_pkg::HS_ACK) ? 1'b1 : (kind == usb_irq_cfg_pkg::HS_NAK) ? 1'b0 : armed;
					clr();
				end
			end
		end
		// Level pin: global gate, late global enable, masked endpoint
		reg_wr(12'h214, 1'b1, 4'hF, 32'h1 << 15);
		hs(3'h2, 1'b1, 1'b0, usb_irq_cfg_pkg::HS_ACK);
		@(negedge CLK);
		`CHECK(IRQ, 1'b1, "global off")
		GLOBAL_IRQ_EN = 1'b1;
		@(negedge CLK);
		`CHECK(IRQ, 1'b0, "pending on global enable")
		clr();
		hs(3'h3, 1'b1, 1'b0, usb_irq_cfg_pkg::HS_ACK);
		@(negedge CLK);
		`CHECK(IRQ, 1'b1, "masked endpoint")
		clr();
		reg_wr(12'h210, 1'b1, 4'h1, 32'hFD);
		pol = 1'b1;
		@(negedge CLK);
		`CHECK(IRQ, 1'b0, "high polarity idle")
		hs(3'h2, 1'b1, 1'b0, usb_irq_cfg_pkg::HS_ACK);
		@(negedge CLK);
		`CHECK(IRQ, 1'b1, "high polarity active")
		clr();
		// Pulsed pin
		reg_wr(12'h210, 1'b1, 4'h1, 32'hFF);
		np = pulses + 8'h01;
		hs(3'h2, 1'b1, 1'b0, usb_irq_cfg_pkg::HS_ACK);
		repeat (PULSE_EXP + 4) @(negedge CLK);
		`CHECK(pulses, np, "one pulse")
		`CHECK(run_len, 8'(PULSE_EXP), "pulse length")
		clr();
		// Bus events, bus reset last
		en = $urandom() | 32'h0000001F;
		reg_wr(12'h214, 1'b1, 4'hF, en);
		reg_rd(12'h216, 1'b0, rd);
		`CHECK(rd, {16'h0000, en[31:16]}, "narrow upper enable half")
		for (int k = 0; k < 5; k++) begin
			BUS_EVENT = usb_irq_cfg_pkg::bus_event_s'(5'(1 << k));
			@(negedge CLK);
			BUS_EVENT = '0;
			`CHECK(IRQ_STATUS[4 - k], 1'b1, "bus event status")
			clr();
		end
		reg_rd(12'h210, 1'b1, rd);
		`CHECK(rd, 32'h000800FF, "config after bus reset")
		reg_rd(12'h214, 1'b1, rd);
		`CHECK(rd, en & 32'h1, "enables after bus reset")
		// Hardware reset in mid-run clears the pin controls
		RESET = 1'b1;
		pol = 1'b0;
		@(negedge CLK);
		RESET = 1'b0;
		reg_rd(12'h210, 1'b1, rd);
		`CHECK(rd, 32'h000800FC, "config after hardware reset")
		close_out();
	end
endmodule
`default_nettype wire
